//--- rtl/touch_probe_capture.v
// two-channel touch probe capture unit with object-dictionary access port
`include "touch_probe_map.vh"
module touch_probe_capture #(
  parameter NUM_PINS = 8
) (
  input wire clock_in, // system clock, 200 MHz
  input wire reset_in, // synchronous reset, active high
  input wire [NUM_PINS-1:0] probe_pin_in, // digital input pins, bit 0 is pin one
  input wire encoder_index_in, // encoder index pulse level
  input wire [31:0] axis_position_in, // current axis position in counts
  input wire od_request_in, // one-cycle object access request
  input wire od_write_in, // 1 write, 0 read
  input wire [15:0] od_index_in, // object index
  input wire [7:0] od_subindex_in, // object sub-index
  input wire [31:0] od_wdata_in, // write data, low bits used
  output reg od_done_out, // one-cycle answer strobe
  output reg od_abort_out, // with done: access refused
  output reg [31:0] od_rdata_out // read data, valid with done
);
  // 16-bit objects use the low half of the data path
  reg [15:0] function_word;
  reg [15:0] select_one;
  reg [15:0] select_two;

  reg [31:0] next_rdata;
  reg next_abort;
  reg source_one;
  reg source_two;

  wire [31:0] time_ns;
  wire [15:0] status_word;
  wire [31:0] one_rise_pos;
  wire [31:0] one_fall_pos;
  wire [31:0] one_rise_time;
  wire [31:0] one_fall_time;
  wire [31:0] two_rise_pos;
  wire [31:0] two_fall_pos;
  wire [31:0] two_rise_time;
  wire [31:0] two_fall_time;

  wire one_rise_stored;
  wire one_fall_stored;
  wire two_rise_stored;
  wire two_fall_stored;

  wire [1:0] source_code_one;
  wire [1:0] source_code_two;
  wire sel_level_one;
  wire sel_level_two;
  wire scalar_sub;
  wire access_ok;
  wire write_accept;
  wire read_accept;
  wire sel_object;
  wire function_write;
  wire select_one_write;
  wire select_two_write;

  // selection entry to pin level; non-negative or out-of-range values give no source
  function entry_pin_level;
    input [15:0] entry;
    input [NUM_PINS-1:0] pins;
    reg [15:0] magnitude;
    reg [15:0] pin_number;
    integer i;
    begin
      magnitude = 16'h0000 - entry;
      entry_pin_level = 1'b0;
      // loop depth follows NUM_PINS; large pin counts lengthen this path
      if (entry[15]) begin
        for (i = 0; i < NUM_PINS; i = i + 1) begin
          pin_number = i[15:0] + 16'h0001;
          if (magnitude == pin_number) begin
            entry_pin_level = pins[i];
          end
        end
      end
    end
  endfunction

  // entries are decoded every cycle, so a new entry acts at once
  assign sel_level_one = entry_pin_level(select_one, probe_pin_in);
  assign sel_level_two = entry_pin_level(select_two, probe_pin_in);
  assign source_code_one = function_word[`TP_FN_ONE_SRC_HI:`TP_FN_ONE_SRC_LO];
  assign source_code_two = function_word[`TP_FN_TWO_SRC_HI:`TP_FN_TWO_SRC_LO];

  // reserved source code yields a quiet source: no edges, no captures
  always @* begin
    case (source_code_one)
      `TP_SRC_PIN: source_one = probe_pin_in[0];
      `TP_SRC_INDEX: source_one = encoder_index_in;
      `TP_SRC_SELECTED: source_one = sel_level_one;
      default: source_one = 1'b0;
    endcase
  end

  // a source switch can itself look like an edge when the two levels differ
  always @* begin
    case (source_code_two)
      `TP_SRC_PIN: source_two = probe_pin_in[1];
      `TP_SRC_INDEX: source_two = encoder_index_in;
      `TP_SRC_SELECTED: source_two = sel_level_two;
      default: source_two = 1'b0;
    endcase
  end

  // stamps wrap after about 4.3 s; software must unwrap differences
  probe_timebase #(
    .STEP_NS(`TP_CLK_PERIOD_NS)
  ) timebase (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .time_ns_out(time_ns)
  );

  // both probes share one timebase so their stamps compare directly
  probe_edge_capture probe_one (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .enable_in(function_word[`TP_FN_ONE_ENABLE]),
    .continuous_in(function_word[`TP_FN_ONE_CONT]),
    .rise_enable_in(function_word[`TP_FN_ONE_RISE]),
    .fall_enable_in(function_word[`TP_FN_ONE_FALL]),
    .source_in(source_one),
    .position_in(axis_position_in),
    .time_in(time_ns),
    .rise_position_out(one_rise_pos),
    .fall_position_out(one_fall_pos),
    .rise_time_out(one_rise_time),
    .fall_time_out(one_fall_time),
    .rise_stored_out(one_rise_stored),
    .fall_stored_out(one_fall_stored)
  );

  probe_edge_capture probe_two (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .enable_in(function_word[`TP_FN_TWO_ENABLE]),
    .continuous_in(function_word[`TP_FN_TWO_CONT]),
    .rise_enable_in(function_word[`TP_FN_TWO_RISE]),
    .fall_enable_in(function_word[`TP_FN_TWO_FALL]),
    .source_in(source_two),
    .position_in(axis_position_in),
    .time_in(time_ns),
    .rise_position_out(two_rise_pos),
    .fall_position_out(two_fall_pos),
    .rise_time_out(two_rise_time),
    .fall_time_out(two_fall_time),
    .rise_stored_out(two_rise_stored),
    .fall_stored_out(two_fall_stored)
  );

  // spare bits tied low so software can compare whole words
  assign status_word = {5'h00,
                        two_fall_stored,
                        two_rise_stored,
                        function_word[`TP_FN_TWO_ENABLE],
                        5'h00,
                        one_fall_stored,
                        one_rise_stored,
                        function_word[`TP_FN_ONE_ENABLE]};

  // every object but the selection record lives at sub-index zero
  assign scalar_sub = (od_subindex_in == `TP_SUB_COUNT);

  // answer decode: read value and refusal for every index and sub-index
  always @* begin
    next_rdata = 32'h00000000;
    next_abort = 1'b0;
    case (od_index_in)
      `TP_IDX_FUNCTION: begin
        next_abort = ~scalar_sub;
        next_rdata = {16'h0000, function_word};
      end
      `TP_IDX_STATUS: begin
        next_abort = ~scalar_sub | od_write_in;
        next_rdata = {16'h0000, status_word};
      end
      `TP_IDX_ONE_RISE_POS: begin
        next_abort = ~scalar_sub | od_write_in;
        next_rdata = one_rise_pos;
      end
      `TP_IDX_ONE_FALL_POS: begin
        next_abort = ~scalar_sub | od_write_in;
        next_rdata = one_fall_pos;
      end
      `TP_IDX_TWO_RISE_POS: begin
        next_abort = ~scalar_sub | od_write_in;
        next_rdata = two_rise_pos;
      end
      `TP_IDX_TWO_FALL_POS: begin
        next_abort = ~scalar_sub | od_write_in;
        next_rdata = two_fall_pos;
      end
      `TP_IDX_ONE_RISE_TIME: begin
        next_abort = ~scalar_sub | od_write_in;
        next_rdata = one_rise_time;
      end
      `TP_IDX_ONE_FALL_TIME: begin
        next_abort = ~scalar_sub | od_write_in;
        next_rdata = one_fall_time;
      end
      `TP_IDX_TWO_RISE_TIME: begin
        next_abort = ~scalar_sub | od_write_in;
        next_rdata = two_rise_time;
      end
      `TP_IDX_TWO_FALL_TIME: begin
        next_abort = ~scalar_sub | od_write_in;
        next_rdata = two_fall_time;
      end
      `TP_IDX_SELECTION: begin
        case (od_subindex_in)
          `TP_SUB_COUNT: begin
            next_abort = od_write_in;
            next_rdata = `TP_SELECTION_ENTRIES;
          end
          `TP_SUB_ONE: begin
            next_rdata = {{16{select_one[15]}}, select_one};
          end
          `TP_SUB_TWO: begin
            next_rdata = {{16{select_two[15]}}, select_two};
          end
          default: begin
            next_abort = 1'b1;
          end
        endcase
      end
      default: begin
        next_abort = 1'b1;
      end
    endcase
  end

  // strobes gated by the refusal decode, so a refused write leaves every register alone
  assign access_ok = od_request_in & ~next_abort;
  assign write_accept = access_ok & od_write_in;
  assign read_accept = access_ok & ~od_write_in;
  assign sel_object = (od_index_in == `TP_IDX_SELECTION);
  assign function_write = write_accept &
                          (od_index_in == `TP_IDX_FUNCTION);
  assign select_one_write = write_accept & sel_object &
                            (od_subindex_in == `TP_SUB_ONE);
  assign select_two_write = write_accept & sel_object &
                            (od_subindex_in == `TP_SUB_TWO);

  // writes take effect at the request edge; refused writes change nothing
  always @(posedge clock_in) begin
    if (reset_in) begin
      function_word <= `TP_FUNCTION_RESET;
      select_one <= `TP_SELECTION_RESET;
      select_two <= `TP_SELECTION_RESET;
    end else begin
      if (function_write) begin
        function_word <= od_wdata_in[15:0] & `TP_FN_WRITE_MASK;
      end
      if (select_one_write) begin
        select_one <= od_wdata_in[15:0];
      end
      if (select_two_write) begin
        select_two <= od_wdata_in[15:0];
      end
    end
  end

  // data cleared on writes and refusals so stale data never passes for an answer
  always @(posedge clock_in) begin
    if (reset_in) begin
      od_done_out <= 1'b0;
      od_abort_out <= 1'b0;
      od_rdata_out <= 32'h00000000;
    end else begin
      od_done_out <= od_request_in;
      od_abort_out <= od_request_in & next_abort;
      if (read_accept) begin
        od_rdata_out <= next_rdata;
      end else if (od_request_in) begin
        od_rdata_out <= 32'h00000000;
      end
    end
  end
endmodule

//--- rtl/touch_probe_map.vh
// object indices, field positions, reset values and timing constants of the touch probe unit
`ifndef TOUCH_PROBE_MAP_VH
`define TOUCH_PROBE_MAP_VH
`define TP_IDX_FUNCTION 16'h60b8
`define TP_IDX_STATUS 16'h60b9
`define TP_IDX_ONE_RISE_POS 16'h60ba
`define TP_IDX_ONE_FALL_POS 16'h60bb
`define TP_IDX_TWO_RISE_POS 16'h60bc
`define TP_IDX_TWO_FALL_POS 16'h60bd
`define TP_IDX_SELECTION 16'h60d0
`define TP_IDX_ONE_RISE_TIME 16'h60d1
`define TP_IDX_ONE_FALL_TIME 16'h60d2
`define TP_IDX_TWO_RISE_TIME 16'h60d3
`define TP_IDX_TWO_FALL_TIME 16'h60d4
`define TP_SUB_COUNT 8'h00
`define TP_SUB_ONE 8'h01
`define TP_SUB_TWO 8'h02
`define TP_SELECTION_ENTRIES 32'h00000002
`define TP_FN_ONE_ENABLE 0
`define TP_FN_ONE_CONT 1
`define TP_FN_ONE_SRC_LO 2
`define TP_FN_ONE_SRC_HI 3
`define TP_FN_ONE_RISE 4
`define TP_FN_ONE_FALL 5
`define TP_FN_TWO_ENABLE 8
`define TP_FN_TWO_CONT 9
`define TP_FN_TWO_SRC_LO 10
`define TP_FN_TWO_SRC_HI 11
`define TP_FN_TWO_RISE 12
`define TP_FN_TWO_FALL 13
`define TP_FN_WRITE_MASK 16'h3f3f
`define TP_ST_ONE_ENABLED 0
`define TP_ST_ONE_RISE 1
`define TP_ST_ONE_FALL 2
`define TP_ST_TWO_ENABLED 8
`define TP_ST_TWO_RISE 9
`define TP_ST_TWO_FALL 10
`define TP_SRC_PIN 2'h0
`define TP_SRC_INDEX 2'h1
`define TP_SRC_SELECTED 2'h2
`define TP_SRC_RESERVED 2'h3
`define TP_FUNCTION_RESET 16'h0000
`define TP_SELECTION_RESET 16'h0000
`define TP_CLK_PERIOD_NS 5
`endif

//--- rtl/probe_timebase.v
// free-running nanosecond timestamp counter for capture events
`include "touch_probe_map.vh"
module probe_timebase #(
  parameter STEP_NS = `TP_CLK_PERIOD_NS
) (
  input wire clock_in, // system clock
  input wire reset_in, // synchronous reset, active high
  output reg [31:0] time_ns_out // nanoseconds since reset, wraps
);
  localparam [31:0] STEP = STEP_NS;

  always @(posedge clock_in) begin
    if (reset_in) begin
      time_ns_out <= 32'h00000000;
    end else begin
      time_ns_out <= time_ns_out + STEP;
    end
  end
endmodule

//--- rtl/probe_edge_capture.v
// one probe channel: edge detection, position and time latching, stored flags
module probe_edge_capture (
  input wire clock_in, // system clock
  input wire reset_in, // synchronous reset, active high
  input wire enable_in, // probe switched on
  input wire continuous_in, // 1 every event, 0 first event only
  input wire rise_enable_in, // capture on rising edges
  input wire fall_enable_in, // capture on falling edges
  input wire source_in, // selected probe source level
  input wire [31:0] position_in, // current axis position
  input wire [31:0] time_in, // current timestamp in ns
  output reg [31:0] rise_position_out, // position at rising edge
  output reg [31:0] fall_position_out, // position at falling edge
  output reg [31:0] rise_time_out, // time at rising edge
  output reg [31:0] fall_time_out, // time at falling edge
  output reg rise_stored_out, // a rising edge value is held
  output reg fall_stored_out // a falling edge value is held
);
  reg source_prev;
  wire rise_seen;
  wire fall_seen;
  wire rise_take;
  wire fall_take;

  // previous level tracks even while disabled, so enabling never sees a stale edge
  assign rise_seen = source_in & ~source_prev;
  assign fall_seen = ~source_in & source_prev;
  assign rise_take = enable_in & rise_enable_in & rise_seen &
                     (continuous_in | ~rise_stored_out);
  assign fall_take = enable_in & fall_enable_in & fall_seen &
                     (continuous_in | ~fall_stored_out);

  always @(posedge clock_in) begin
    if (reset_in) begin
      source_prev <= 1'b0;
      rise_position_out <= 32'h00000000;
      fall_position_out <= 32'h00000000;
      rise_time_out <= 32'h00000000;
      fall_time_out <= 32'h00000000;
      rise_stored_out <= 1'b0;
      fall_stored_out <= 1'b0;
    end else begin
      source_prev <= source_in;
      if (rise_take) begin
        rise_position_out <= position_in;
        rise_time_out <= time_in;
      end
      if (fall_take) begin
        fall_position_out <= position_in;
        fall_time_out <= time_in;
      end
      if (!enable_in) begin
        rise_stored_out <= 1'b0;
        fall_stored_out <= 1'b0;
      end else begin
        if (rise_take) begin
          rise_stored_out <= 1'b1;
        end
        if (fall_take) begin
          fall_stored_out <= 1'b1;
        end
      end
    end
  end
endmodule

//--- tb/tp_capture_props.sv
// concurrent checks on the object access port of the touch probe unit
module tp_capture_props #(
  parameter NUM_PINS = 8
) (
  input logic clock_in, // system clock
  input logic reset_in, // synchronous reset
  input logic od_request_in, // access request
  input logic od_write_in, // write select
  input logic [15:0] od_index_in, // object index
  input logic [7:0] od_subindex_in, // sub-index
  input logic od_done_out, // answer strobe
  input logic od_abort_out, // refusal flag
  input logic [31:0] od_rdata_out // read data
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (reset_in);
  logic rd;
  logic wr;
  logic known;
  assign rd = od_request_in && !od_write_in;
  assign wr = od_request_in && od_write_in;
  assign known = (od_index_in >= 16'h60b8 && od_index_in <= 16'h60bd) ||
                 (od_index_in >= 16'h60d0 && od_index_in <= 16'h60d4);
  property p_answer;
    od_request_in |=> od_done_out;
  endproperty
  a_answer: assert property (p_answer) else $error("no answer one cycle after request");
  property p_no_spurious;
    od_done_out |-> $past(od_request_in);
  endproperty
  a_no_spurious: assert property (p_no_spurious) else $error("answer without request");
  property p_status_ro;
    wr && od_index_in == 16'h60b9 |=> od_done_out && od_abort_out;
  endproperty
  a_status_ro: assert property (p_status_ro) else $error("status write accepted");
  property p_pos_ro;
    wr && od_index_in >= 16'h60ba && od_index_in <= 16'h60bd |=> od_abort_out;
  endproperty
  a_pos_ro: assert property (p_pos_ro) else $error("position write accepted");
  property p_time_ro;
    wr && od_index_in >= 16'h60d1 && od_index_in <= 16'h60d4 |=> od_abort_out;
  endproperty
  a_time_ro: assert property (p_time_ro) else $error("time write accepted");
  property p_sel_count;
    rd && od_index_in == 16'h60d0 && od_subindex_in == 8'h00 |=>
      !od_abort_out && od_rdata_out == 32'h00000002;
  endproperty
  a_sel_count: assert property (p_sel_count) else $error("entry count wrong");
  property p_sel_sign;
    rd && od_index_in == 16'h60d0 && od_subindex_in inside {8'h01, 8'h02} |=>
      od_rdata_out[31:16] == {16{od_rdata_out[15]}};
  endproperty
  a_sel_sign: assert property (p_sel_sign) else $error("entry not sign extended");
  property p_fn_reserved;
    rd && od_index_in == 16'h60b8 && od_subindex_in == 8'h00 |=>
      !od_abort_out && (od_rdata_out & 32'hffffc0c0) == 32'h0;
  endproperty
  a_fn_reserved: assert property (p_fn_reserved) else $error("function spare bits set");
  property p_st_reserved;
    rd && od_index_in == 16'h60b9 && od_subindex_in == 8'h00 |=>
      !od_abort_out && (od_rdata_out & 32'hfffff8f8) == 32'h0;
  endproperty
  a_st_reserved: assert property (p_st_reserved) else $error("status spare bits set");
  property p_unmapped;
    od_request_in && !known |=> od_done_out && od_abort_out && od_rdata_out == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
  c_stored: cover property (rd && od_index_in == 16'h60b9 ##1 od_rdata_out[1]);
  c_refused: cover property (od_done_out && od_abort_out);
  c_back_to_back: cover property (od_request_in ##1 od_request_in);
endmodule

bind touch_probe_capture tp_capture_props #(.NUM_PINS(NUM_PINS)) u_props (
  .clock_in(clock_in),
  .reset_in(reset_in),
  .od_request_in(od_request_in),
  .od_write_in(od_write_in),
  .od_index_in(od_index_in),
  .od_subindex_in(od_subindex_in),
  .od_done_out(od_done_out),
  .od_abort_out(od_abort_out),
  .od_rdata_out(od_rdata_out)
);

//--- tb/probe_far_side.sv
// far-side model: probe pins, encoder index and axis position
module probe_far_side #(
  parameter NUM_PINS = 8
) (
  input logic clock_in, // system clock
  input logic reset_in, // synchronous reset
  input logic [NUM_PINS-1:0] pin_cmd_in, // wanted pin levels
  input logic index_cmd_in, // wanted index level
  input logic [31:0] position_cmd_in, // wanted axis position
  output logic [NUM_PINS-1:0] pin_out, // pin levels to the unit
  output logic index_out, // index level to the unit
  output logic [31:0] position_out // axis position to the unit
);
  timeunit 1ns;
  timeprecision 100ps;
  // registered so pin and position change in the same cycle, as synchronised inputs do
  always @(posedge clock_in) begin
    if (reset_in) begin
      pin_out <= '0;
      index_out <= 1'b0;
      position_out <= 32'h0;
    end else begin
      pin_out <= pin_cmd_in;
      index_out <= index_cmd_in;
      position_out <= position_cmd_in;
    end
  end
endmodule

//--- tb/tb.sv
// self-checking bench for the touch probe capture unit
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock_in, reset_in, index_cmd, od_request_in, od_write_in;
  logic [7:0] pin_cmd, probe_pin;
  logic [31:0] pos_cmd, axis_pos, od_wdata_in, r, t1;
  logic [15:0] od_index_in;
  logic [7:0] od_subindex_in;
  logic encoder_index, od_done_out, od_abort_out, a;
  logic [31:0] od_rdata_out;
  int err_count = 0;
  int n_tests = 0;
  probe_far_side #(.NUM_PINS(8)) u_far (.clock_in(clock_in), .reset_in(reset_in),
    .pin_cmd_in(pin_cmd), .index_cmd_in(index_cmd), .position_cmd_in(pos_cmd),
    .pin_out(probe_pin), .index_out(encoder_index), .position_out(axis_pos));
  touch_probe_capture #(.NUM_PINS(8)) u_dut (.clock_in(clock_in), .reset_in(reset_in),
    .probe_pin_in(probe_pin), .encoder_index_in(encoder_index), .axis_position_in(axis_pos),
    .od_request_in(od_request_in), .od_write_in(od_write_in), .od_index_in(od_index_in),
    .od_subindex_in(od_subindex_in), .od_wdata_in(od_wdata_in), .od_done_out(od_done_out),
    .od_abort_out(od_abort_out), .od_rdata_out(od_rdata_out));
  initial begin
    clock_in = 1'b0;
    forever #2.5 clock_in = ~clock_in;
  end
  task print_verdict;
    if (err_count == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task od(input logic wr, input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] wd);
    int n;
    @(posedge clock_in);
    #1;
    od_request_in = 1'b1;
    od_write_in = wr;
    od_index_in = idx;
    od_subindex_in = sub;
    od_wdata_in = wd;
    @(posedge clock_in);
    #1;
    od_request_in = 1'b0;
    n = 0;
    // bounded wait: a lost answer ends the run instead of hanging it
    while (od_done_out !== 1'b1 && n < 8) begin
      @(posedge clock_in);
      #1;
      n++;
    end
    if (od_done_out !== 1'b1) begin
      check("answer strobe", 32'h0, 32'h1);
      print_verdict();
    end else begin
      r = od_rdata_out;
      a = od_abort_out;
    end
  endtask
  task rd_chk(input string what, input logic [15:0] idx, input logic [7:0] sub,
              input logic [31:0] exp, input logic exp_ab);
    od(1'b0, idx, sub, 32'h0);
    check(what, r, exp);
    check({what, " refusal"}, {31'h0, a}, {31'h0, exp_ab});
  endtask
  task wr_chk(input string what, input logic [15:0] idx, input logic [7:0] sub,
              input logic [31:0] wd, input logic exp_ab);
    od(1'b1, idx, sub, wd);
    check(what, {31'h0, a}, {31'h0, exp_ab});
    check({what, " data"}, r, 32'h0);
  endtask
  // new levels reach the unit one edge later and are captured on the edge after that
  task drive(input logic [7:0] pins, input logic idx, input logic [31:0] pos);
    @(posedge clock_in);
    #1;
    pin_cmd = pins;
    index_cmd = idx;
    pos_cmd = pos;
    repeat (2) @(posedge clock_in);
    #1;
  endtask
  task scen_registers;
    rd_chk("function reset", 16'h60b8, 8'h00, 32'h0, 1'b0);
    rd_chk("status reset", 16'h60b9, 8'h00, 32'h0, 1'b0);
    rd_chk("entry count", 16'h60d0, 8'h00, 32'h2, 1'b0);
    wr_chk("entry count write", 16'h60d0, 8'h00, 32'h5, 1'b1);
    wr_chk("status write", 16'h60b9, 8'h00, 32'h7, 1'b1);
    wr_chk("position write", 16'h60ba, 8'h00, 32'h5, 1'b1);
    wr_chk("time write", 16'h60d1, 8'h00, 32'h5, 1'b1);
    wr_chk("entry three", 16'h60d0, 8'h03, 32'h1, 1'b1);
    rd_chk("unmapped", 16'h60be, 8'h00, 32'h0, 1'b1);
    wr_chk("function all", 16'h60b8, 8'h00, 32'hffff, 1'b0);
    rd_chk("function mask", 16'h60b8, 8'h00, 32'h3f3f, 1'b0);
    rd_chk("reserved source quiet", 16'h60b9, 8'h00, 32'h0101, 1'b0);
    wr_chk("entry one", 16'h60d0, 8'h01, 32'hfffe, 1'b0);
    rd_chk("entry one", 16'h60d0, 8'h01, 32'hfffffffe, 1'b0);
    wr_chk("entry two", 16'h60d0, 8'h02, 32'hffff, 1'b0);
    rd_chk("entry two", 16'h60d0, 8'h02, 32'hffffffff, 1'b0);
    wr_chk("function off", 16'h60b8, 8'h00, 32'h0, 1'b0);
  endtask
  task scen_first_event;
    wr_chk("probe one on", 16'h60b8, 8'h00, 32'h0031, 1'b0);
    rd_chk("enabled", 16'h60b9, 8'h00, 32'h0001, 1'b0);
    drive(8'h01, 1'b0, 32'h80000010);
    rd_chk("rise flag", 16'h60b9, 8'h00, 32'h0003, 1'b0);
    drive(8'h00, 1'b0, 32'h7ffffff0);
    rd_chk("both flags", 16'h60b9, 8'h00, 32'h0007, 1'b0);
    drive(8'h01, 1'b0, 32'h00000033);
    rd_chk("rise position", 16'h60ba, 8'h00, 32'h80000010, 1'b0);
    rd_chk("fall position", 16'h60bb, 8'h00, 32'h7ffffff0, 1'b0);
    od(1'b0, 16'h60d1, 8'h00, 32'h0);
    t1 = r;
    // five clocks lie between the rising and the falling capture edge
    rd_chk("time gap", 16'h60d2, 8'h00, t1 + 32'd25, 1'b0);
    wr_chk("probe one off", 16'h60b8, 8'h00, 32'h0000, 1'b0);
    rd_chk("flags cleared", 16'h60b9, 8'h00, 32'h0000, 1'b0);
    wr_chk("probe one rise only", 16'h60b8, 8'h00, 32'h0011, 1'b0);
    rd_chk("re-enabled", 16'h60b9, 8'h00, 32'h0001, 1'b0);
    drive(8'h00, 1'b0, 32'h00000044);
    rd_chk("fall ignored", 16'h60b9, 8'h00, 32'h0001, 1'b0);
    rd_chk("fall value kept", 16'h60bb, 8'h00, 32'h7ffffff0, 1'b0);
    drive(8'h01, 1'b0, 32'h00000055);
    rd_chk("rearmed", 16'h60ba, 8'h00, 32'h00000055, 1'b0);
  endtask
  task scen_continuous;
    wr_chk("probe two index", 16'h60b8, 8'h00, 32'h1700, 1'b0);
    drive(8'h01, 1'b1, 32'h00000100);
    od(1'b0, 16'h60d3, 8'h00, 32'h0);
    t1 = r;
    rd_chk("two rise", 16'h60b9, 8'h00, 32'h0300, 1'b0);
    drive(8'h01, 1'b0, 32'h00000200);
    rd_chk("two fall off", 16'h60b9, 8'h00, 32'h0300, 1'b0);
    drive(8'h01, 1'b1, 32'hfffffff0);
    rd_chk("two continuous", 16'h60bc, 8'h00, 32'hfffffff0, 1'b0);
    // twelve clocks lie between the two rising capture edges
    rd_chk("two rise time", 16'h60d3, 8'h00, t1 + 32'd60, 1'b0);
    rd_chk("two fall none", 16'h60bd, 8'h00, 32'h0, 1'b0);
    rd_chk("two fall time none", 16'h60d4, 8'h00, 32'h0, 1'b0);
  endtask
  task scen_selected;
    // both probes off and all sources low first, so the switch itself makes no edge
    wr_chk("both off", 16'h60b8, 8'h00, 32'h0000, 1'b0);
    drive(8'h00, 1'b0, 32'h00000000);
    wr_chk("both selected", 16'h60b8, 8'h00, 32'h1919, 1'b0);
    drive(8'h02, 1'b0, 32'h00000777);
    drive(8'h03, 1'b0, 32'h00000888);
    rd_chk("selected status", 16'h60b9, 8'h00, 32'h0303, 1'b0);
    rd_chk("pin two via entry", 16'h60ba, 8'h00, 32'h00000777, 1'b0);
    rd_chk("pin one via entry", 16'h60bc, 8'h00, 32'h00000888, 1'b0);
  endtask
  initial begin
    reset_in = 1'b1;
    pin_cmd = 8'h00;
    index_cmd = 1'b0;
    pos_cmd = 32'h0;
    od_request_in = 1'b0;
    od_write_in = 1'b0;
    od_index_in = 16'h0;
    od_subindex_in = 8'h0;
    od_wdata_in = 32'h0;
    repeat (2) @(posedge clock_in);
    #1;
    reset_in = 1'b0;
    scen_registers();
    scen_first_event();
    scen_continuous();
    scen_selected();
    print_verdict();
  end
endmodule
